// File: hdl/rbf_pkg.sv
/*
 * shared constants and carriers for the ready-bus flow control and messaging block.
 * assumes a single 125 MHz clock and an APB register port with 32-bit data.
 */
package rbf_pkg;
	// register byte offsets
	localparam logic [7:0] REG_RX_COUNT = 8'h00;
	localparam logic [7:0] REG_FLOW_BYTE = 8'h04;
	localparam logic [7:0] REG_CONTROL = 8'h08;
	localparam logic [7:0] REG_INSTR = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_MSG_OUT = 8'h14;
	localparam logic [7:0] REG_MSG_IN = 8'h18;
	// field positions
	localparam int RXCNT_READY_LSB = 0;
	localparam int RXCNT_REQ_LSB = 8;
	localparam int RXCNT_VALID_BIT = 16;
	localparam int FLOW_MAC_LSB = 8;
	localparam int CTRL_SLAVE_BIT = 0;
	localparam int CTRL_MODE3_BIT = 1;
	localparam int INSTR_LEN_LSB = 4;
	// reset values
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [4:0] CTRL_IDLE_N = 5'h1f;
	// distinct active-low control encodings on the five lines
	localparam logic [4:0] ENC_FLOW_N = 5'h1e;
	localparam logic [4:0] ENC_SLAVE_FETCH_N = 5'h1d;
	localparam logic [4:0] ENC_CHAIN_FETCH_N = 5'h1b;
	localparam logic [4:0] ENC_SEND_N = 5'h17;
	// timing
	localparam int NOP_NS = 8;
	localparam int CLK_NS = 8;
	localparam int NOP_CYCLES = (NOP_NS + CLK_NS - 1) / CLK_NS;
	localparam int MAX_LONGWORDS = 8;
	localparam int MSG_BITS = 16;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_RX_PUSH,
		OP_RX_FETCH,
		OP_TX_FETCH,
		OP_FLOW,
		OP_SLAVE_FETCH,
		OP_CHAIN_FETCH,
		OP_SEND
	} rbf_op_t;

	typedef struct packed {
		logic [4:0] ctrlN;
		logic [7:0] data;
		logic dataOe;
		logic [6:0] devSel;
	} rbf_bus_out_t;
endpackage

// File: hdl/rbf_word_pack.sv
/*
 * byte-to-longword assembler for incoming ready-bus data, first byte lowest.
 * assumes byte strobes are one cycle each and start is pulsed before or with
 * the first byte of a word; a start that meets a byte keeps that byte at lane zero.
 */
module rbf_word_pack (
	input wire logic clk,
	input wire logic rstN,
	input wire logic start,
	input wire logic byteStb,
	input wire logic [7:0] byteIn,
	output logic wordStb,
	output logic [31:0] word
);
	logic [1:0] lane;
	logic [23:0] partial;
	wire [1:0] at = start ? 2'h0 : lane;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			lane <= 2'h0;
			partial <= 24'h000000;
			wordStb <= 1'b0;
			word <= 32'h00000000;
		end else begin
			wordStb <= 1'b0;
			if (byteStb) begin
				lane <= at + 2'h1;
				if (at == 2'h3) begin
					word <= {byteIn, partial};
					wordStb <= 1'b1;
				end else begin
					partial[at*8 +: 8] <= byteIn;
				end
			end else if (start) begin
				lane <= 2'h0;
			end
		end
	end
endmodule

// File: hdl/rbf_ready_bus.sv
/*
 * ready-bus count tracking, flow-control byte drive and get/send messaging.
 * assumes instructions arrive from the sequencer as one-cycle strobes or via APB,
 * bus inputs are synchronous to clk, and the external fifos are glue logic.
 */
// Local design decisions: the address map and the APB interface to the registers.
module rbf_ready_bus (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic instrStb,
	input wire rbf_pkg::rbf_op_t instrOp,
	input wire logic [3:0] instrLen,
	input wire logic loopStart,
	input wire logic rxReqDone,
	input wire logic [4:0] busCtrlInN,
	input wire logic [7:0] busDataIn,
	output rbf_pkg::rbf_bus_out_t busOut,
	output logic busy
);
	//////////////////////////////////////////////////////////////////////////
	logic rstMeta;
	logic rstN;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN <= rstMeta;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {ST_IDLE, ST_NOP, ST_FLOW, ST_SEND, ST_GET} rbf_state_t;
	rbf_state_t state;
	logic [7:0] rxReadyCount;
	logic [7:0] rxReqCount;
	logic [7:0] rxReqSnap;
	logic [7:0] flowByte;
	logic [2:0] flowMac;
	logic flowValid;
	logic slaveMode;
	logic mode3;
	logic fetchSeen;
	logic snoopSeen;
	logic [4:0] byteCnt;
	logic [4:0] byteGoal;
	logic [31:0] msgOut;
	logic msgOutValid;
	logic [31:0] msgIn;
	logic msgInValid;
	logic [4:0] ctrlN;
	logic [7:0] dataOut;
	logic dataOe;
	logic [6:0] devSel;
	logic wordStb;
	logic [31:0] word;

	wire apbWr = psel && penable && pwrite;
	wire apbRd = psel && penable && !pwrite;
	wire selRxCount = paddr == rbf_pkg::REG_RX_COUNT;
	wire selFlow = paddr == rbf_pkg::REG_FLOW_BYTE;
	wire selCtrl = paddr == rbf_pkg::REG_CONTROL;
	wire selInstr = paddr == rbf_pkg::REG_INSTR;
	wire selStatus = paddr == rbf_pkg::REG_STATUS;
	wire selMsgOut = paddr == rbf_pkg::REG_MSG_OUT;
	wire selMsgIn = paddr == rbf_pkg::REG_MSG_IN;
	wire mapped = selRxCount | selFlow | selCtrl | selInstr | selStatus | selMsgOut | selMsgIn;

	// sequencer strobe wins over software-issued instruction in the same cycle
	wire swInstr = apbWr && selInstr && !instrStb;
	wire opStb = instrStb || swInstr;
	wire rbf_pkg::rbf_op_t op = instrStb ? instrOp : rbf_pkg::rbf_op_t'(pwdata[2:0]);
	wire [3:0] opLen = instrStb ? instrLen : pwdata[rbf_pkg::INSTR_LEN_LSB +: 4];
	wire accept = opStb && state == ST_IDLE;
	wire isMsg = op == rbf_pkg::OP_SLAVE_FETCH || op == rbf_pkg::OP_CHAIN_FETCH
		|| op == rbf_pkg::OP_SEND;
	wire msgOk = mode3 && !slaveMode && isMsg;
	wire lenOk = opLen >= 4'h1 && opLen <= 4'(rbf_pkg::MAX_LONGWORDS);
	// a fetch in the loop-start cycle belongs to the new loop
	wire firstFetch = accept && (!fetchSeen || loopStart)
		&& (op == rbf_pkg::OP_RX_FETCH || op == rbf_pkg::OP_TX_FETCH);

	// slave snoop: only slave fetch and send encodings are answered
	wire snoopSend = slaveMode && mode3 && busCtrlInN == rbf_pkg::ENC_SEND_N;
	wire snoopGet = slaveMode && mode3 && busCtrlInN == rbf_pkg::ENC_SLAVE_FETCH_N;
	// a snooped send restarts the assembler on its first byte
	wire packStart = accept || (state == ST_IDLE && snoopSend && !snoopSeen);
	wire packByte = state == ST_GET || snoopSend;
	wire [1:0] nextLane = byteCnt[1:0] + 2'h1;

	//////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			rxReadyCount <= rbf_pkg::RST_COUNT;
			rxReqCount <= rbf_pkg::RST_COUNT;
			rxReqSnap <= rbf_pkg::RST_COUNT;
			fetchSeen <= 1'b0;
			snoopSeen <= 1'b0;
		end else begin
			snoopSeen <= snoopSend;
			if (accept && op == rbf_pkg::OP_RX_PUSH)
				rxReadyCount <= rxReadyCount + 8'h01;
			if (rxReqDone)
				rxReqCount <= rxReqCount + 8'h01;
			if (firstFetch)
				rxReqSnap <= rxReqCount;
			if (firstFetch)
				fetchSeen <= 1'b1;
			else if (loopStart)
				fetchSeen <= 1'b0;
		end
	end

	// flow byte register; a new write sets valid, and that set wins over consumption
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			flowByte <= 8'h00;
			flowMac <= 3'h0;
			flowValid <= 1'b0;
			slaveMode <= 1'b0;
			mode3 <= 1'b0;
		end else begin
			if (apbWr && selFlow) begin
				flowByte <= pwdata[7:0];
				flowMac <= pwdata[rbf_pkg::FLOW_MAC_LSB +: 3];
				flowValid <= 1'b1;
			end else if (accept && op == rbf_pkg::OP_FLOW && !slaveMode) begin
				flowValid <= 1'b0;
			end
			if (apbWr && selCtrl) begin
				slaveMode <= pwdata[rbf_pkg::CTRL_SLAVE_BIT];
				mode3 <= pwdata[rbf_pkg::CTRL_MODE3_BIT];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// outgoing message word: drained once per send, zero when empty
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			msgOut <= 32'h00000000;
			msgOutValid <= 1'b0;
		end else if (apbWr && selMsgOut) begin
			msgOut <= pwdata;
			msgOutValid <= 1'b1;
		end else if ((state == ST_SEND || snoopGet) && byteCnt[1:0] == 2'h3) begin
			msgOut <= 32'h00000000;
			msgOutValid <= 1'b0;
		end
	end

	// incoming word; a read empties it, a new word arriving wins
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			msgIn <= 32'h00000000;
			msgInValid <= 1'b0;
		end else if (wordStb) begin
			msgIn <= word;
			msgInValid <= 1'b1;
		end else if (apbRd && selMsgIn) begin
			msgIn <= 32'h00000000;
			msgInValid <= 1'b0;
		end
	end

	rbf_word_pack u_pack (
		.clk(clk),
		.rstN(rstN),
		.start(packStart),
		.byteStb(packByte),
		.byteIn(busDataIn),
		.wordStb(wordStb),
		.word(word)
	);

	//////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state <= ST_IDLE;
			byteCnt <= 5'h00;
			byteGoal <= 5'h00;
			ctrlN <= rbf_pkg::CTRL_IDLE_N;
			dataOut <= 8'h00;
			dataOe <= 1'b0;
			devSel <= 7'h00;
		end else begin
			unique case (state)
				ST_IDLE: begin
					byteCnt <= 5'h00;
					ctrlN <= rbf_pkg::CTRL_IDLE_N;
					dataOe <= 1'b0;
					devSel <= 7'h00;
					if (snoopGet) begin
						// slave answers a fetch with its outgoing word, zero if none
						dataOut <= msgOut[byteCnt[1:0]*8 +: 8];
						dataOe <= 1'b1;
						byteCnt <= byteCnt + 5'h01;
					end
					if (accept && op == rbf_pkg::OP_FLOW && !slaveMode) begin
						if (flowValid) begin
							state <= ST_FLOW;
							ctrlN <= rbf_pkg::ENC_FLOW_N;
							dataOut <= flowByte;
							dataOe <= 1'b1;
							if (flowMac < 3'h7)
								devSel[flowMac] <= 1'b1;
						end else begin
							state <= ST_NOP;
						end
					end else if (accept && msgOk && lenOk) begin
						// length in longwords, four bytes each
						byteGoal <= {opLen[2:0], 2'h0} - 5'h01;
						if (op == rbf_pkg::OP_SEND) begin
							state <= ST_SEND;
							ctrlN <= rbf_pkg::ENC_SEND_N;
							dataOut <= msgOut[7:0];
							dataOe <= 1'b1;
						end else begin
							state <= ST_GET;
							// encoding picks slave or external chain fifo
							ctrlN <= op == rbf_pkg::OP_SLAVE_FETCH ? rbf_pkg::ENC_SLAVE_FETCH_N
								: rbf_pkg::ENC_CHAIN_FETCH_N;
						end
					end
				end
				ST_NOP: state <= ST_IDLE;
				ST_FLOW: begin
					state <= ST_IDLE;
					ctrlN <= rbf_pkg::CTRL_IDLE_N;
					dataOe <= 1'b0;
					devSel <= 7'h00;
				end
				ST_SEND, ST_GET: begin
					byteCnt <= byteCnt + 5'h01;
					// the word drains after its last byte, so later longwords are zeros
					if (state == ST_SEND)
						dataOut <= byteCnt[1:0] == 2'h3 ? 8'h00 : msgOut[nextLane*8 +: 8];
					if (byteCnt == byteGoal) begin
						state <= ST_IDLE;
						ctrlN <= rbf_pkg::CTRL_IDLE_N;
						dataOe <= 1'b0;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	assign busOut = '{ctrlN: ctrlN, data: dataOut, dataOe: dataOe, devSel: devSel};
	assign busy = state != ST_IDLE;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	wire [31:0] rdRxCount = {15'h0000, flowValid, rxReqSnap, rxReadyCount};
	wire [31:0] rdStatus = {26'h0, msgInValid, msgOutValid, fetchSeen, busy, mode3, slaveMode};
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite)
			prdata <= selRxCount ? rdRxCount
				: selFlow ? {21'h0, flowMac, flowByte}
				: selCtrl ? {30'h0, mode3, slaveMode}
				: selStatus ? rdStatus
				: selMsgIn ? msgIn
				: 32'h00000000;
	end

	//////////////////////////////////////////////////////////////////////////
	a_push_count: assert property (@(posedge clk) disable iff (!rstN)
		accept && op == rbf_pkg::OP_RX_PUSH |=> rxReadyCount == $past(rxReadyCount) + 8'h01)
		else $error("ready count did not step");
	a_req_count: assert property (@(posedge clk) disable iff (!rstN)
		rxReqDone |=> rxReqCount == $past(rxReqCount) + 8'h01)
		else $error("request count did not step");
	a_snap_copy: assert property (@(posedge clk) disable iff (!rstN)
		firstFetch |=> rxReqSnap == $past(rxReqCount))
		else $error("request snapshot wrong");
	a_flow_valid: assert property (@(posedge clk) disable iff (!rstN)
		apbWr && selFlow |=> flowValid)
		else $error("flow valid not set");
	sequence s_flow_go;
		accept && op == rbf_pkg::OP_FLOW && flowValid && !slaveMode;
	endsequence
	a_flow_drive: assert property (@(posedge clk) disable iff (!rstN)
		s_flow_go |=> busOut.dataOe && busOut.data == $past(flowByte) ##1 !busOut.dataOe)
		else $error("flow byte not driven once");
	a_flow_nop: assert property (@(posedge clk) disable iff (!rstN)
		accept && op == rbf_pkg::OP_FLOW && !flowValid |=> busy && !busOut.dataOe ##1 !busy)
		else $error("flow nop not one cycle");
	a_slave_quiet: assert property (@(posedge clk) disable iff (!rstN)
		slaveMode |-> busOut.devSel == 7'h00)
		else $error("slave drove flow selects");
	a_msg_mode: assert property (@(posedge clk) disable iff (!rstN)
		accept && isMsg && !mode3 |=> !busy)
		else $error("messaging outside three-plus mode");
	a_send_len: assert property (@(posedge clk) disable iff (!rstN)
		accept && op == rbf_pkg::OP_SEND && msgOk && lenOk && opLen == 4'h1
		|=> (busOut.ctrlN == rbf_pkg::ENC_SEND_N) [*4] ##1 busOut.ctrlN == rbf_pkg::CTRL_IDLE_N)
		else $error("send length wrong");
	a_len_refuse: assert property (@(posedge clk) disable iff (!rstN)
		accept && isMsg && !lenOk |=> !busy)
		else $error("bad get length accepted");
	sequence s_chain_go;
		accept && msgOk && lenOk && op == rbf_pkg::OP_CHAIN_FETCH;
	endsequence
	a_chain_code: assert property (@(posedge clk) disable iff (!rstN)
		s_chain_go |=> busOut.ctrlN == rbf_pkg::ENC_CHAIN_FETCH_N && !busOut.dataOe)
		else $error("chain fetch code wrong");
	a_snoop_reply: assert property (@(posedge clk) disable iff (!rstN)
		state == ST_IDLE && snoopGet |=> busOut.dataOe && busOut.ctrlN == rbf_pkg::CTRL_IDLE_N)
		else $error("slave did not answer fetch");
	a_word_store: assert property (@(posedge clk) disable iff (!rstN)
		wordStb |=> msgInValid && msgIn == $past(word))
		else $error("assembled word not stored");
endmodule

// File: test/rbf_peer_model.sv
/*
 * far-side peer on the ready bus: a slave or chained fifo answering fetches,
 * and a master sending to the block while it snoops as slave.
 * assumes sendGo and getGo are driven just after rising edges.
 */
module rbf_peer_model #(
	parameter logic [31:0] REPLY = 32'hc3b2a190
) (
	input wire logic clk,
	input wire rbf_pkg::rbf_bus_out_t busOut,
	input wire logic sendGo,
	input wire logic getGo,
	input wire logic [31:0] sendWord,
	output logic [4:0] busCtrlInN,
	output logic [7:0] busDataIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] idx = 2'h0;
	logic [7:0] held = 8'h00;
	logic fetch;
	////////////////////////////////////////////////////////////////
	// external decode of both fetch codes gates the reply fifo
	assign fetch = busOut.ctrlN == rbf_pkg::ENC_SLAVE_FETCH_N
		|| busOut.ctrlN == rbf_pkg::ENC_CHAIN_FETCH_N;
	assign busCtrlInN = sendGo ? rbf_pkg::ENC_SEND_N
		: getGo ? rbf_pkg::ENC_SLAVE_FETCH_N : rbf_pkg::CTRL_IDLE_N;
	// released bus shows the inverse so a stale byte never looks valid
	assign busDataIn = sendGo ? sendWord[idx*8 +: 8] : fetch ? REPLY[idx*8 +: 8] : ~held;
	always @(posedge clk) begin
		held <= busDataIn;
		idx <= (sendGo || fetch) ? idx + 2'h1 : 2'h0;
	end
endmodule

// File: test/rbf_ready_bus_bench.sv
/*
 * self-checking bench for the ready-bus count, flow and messaging block.
 * assumes the peer model on the far side and the zero-wait apb port.
 */
module rbf_ready_bus_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] REPLY = 32'hc3b2a190;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic pready, pslverr, busy, lastErr;
	logic instrStb = 1'b0, loopStart = 1'b0, rxReqDone = 1'b0, sendGo = 1'b0, getGo = 1'b0;
	rbf_pkg::rbf_op_t instrOp = rbf_pkg::OP_NONE;
	logic [3:0] instrLen = 4'h0;
	logic [4:0] busCtrlInN;
	logic [7:0] busDataIn;
	rbf_pkg::rbf_bus_out_t busOut;
	logic [31:0] sendWord = 32'h5a6b7c8d;
	int badCount = 0, numChecks = 0, cyc = 0;

	always #4 clk = ~clk;
	rbf_ready_bus dut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .instrStb, .instrOp, .instrLen, .loopStart, .rxReqDone,
		.busCtrlInN, .busDataIn, .busOut, .busy);
	rbf_peer_model #(.REPLY(REPLY)) peer (.clk, .busOut, .sendGo, .getGo, .sendWord,
		.busCtrlInN, .busDataIn);
	////////////////////////////////////////////////////////////////
	task automatic endOfTest;
		if (badCount == 0 && numChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		numChecks++;
		if (got !== exp) begin
			badCount++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// ends once pready is high; a pready that never rises is caught only by the bench timeout
		while (pready !== 1'b1)
			@(posedge clk);
		rdv = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic idle;
		#1;
		while (busy !== 1'b0) begin
			@(posedge clk);
			#1;
		end
	endtask
	// returns in the time step of the edge that takes the instruction
	task automatic instr(input rbf_pkg::rbf_op_t op, input logic [3:0] len);
		idle;
		@(posedge clk);
		instrStb <= 1'b1;
		instrOp <= op;
		instrLen <= len;
		@(posedge clk);
		instrStb <= 1'b0;
	endtask
	task automatic pulse(input logic req, input int n);
		repeat (n) begin
			@(posedge clk);
			if (req) rxReqDone <= 1'b1; else loopStart <= 1'b1;
			@(posedge clk);
			rxReqDone <= 1'b0;
			loopStart <= 1'b0;
		end
	endtask
	task automatic next;
		@(posedge clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic testCounts;
		apb(1'b0, rbf_pkg::REG_RX_COUNT, 32'h0);
		check("count at reset", 32'h0, rdv);
		repeat (3) instr(rbf_pkg::OP_RX_PUSH, 4'h0);
		apb(1'b0, rbf_pkg::REG_RX_COUNT, 32'h0);
		check("ready count", 32'h3, rdv & 32'hff);
		repeat (253) instr(rbf_pkg::OP_RX_PUSH, 4'h0);
		apb(1'b0, rbf_pkg::REG_RX_COUNT, 32'h0);
		check("count wrap", 32'h0, rdv & 32'hff);
		apb(1'b1, rbf_pkg::REG_INSTR, 32'(rbf_pkg::OP_RX_PUSH));
		apb(1'b0, rbf_pkg::REG_RX_COUNT, 32'h0);
		check("software push", 32'h1, rdv & 32'hff);
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped error", 32'h1, lastErr);
	endtask
	task automatic testSnapshot;
		pulse(1'b1, 2);
		pulse(1'b0, 1);
		instr(rbf_pkg::OP_RX_FETCH, 4'h1);
		pulse(1'b1, 1);
		instr(rbf_pkg::OP_TX_FETCH, 4'h1);
		idle;
		apb(1'b0, rbf_pkg::REG_RX_COUNT, 32'h0);
		check("first fetch only", 32'h2, rdv[15:8]);
		pulse(1'b0, 1);
		instr(rbf_pkg::OP_TX_FETCH, 4'h1);
		idle;
		apb(1'b0, rbf_pkg::REG_RX_COUNT, 32'h0);
		check("request count", 32'h3, rdv[15:8]);
	endtask
	task automatic testFlow;
		apb(1'b1, rbf_pkg::REG_FLOW_BYTE, 32'h2a5);
		apb(1'b0, rbf_pkg::REG_RX_COUNT, 32'h0);
		check("flow valid", 32'h1, rdv[16]);
		instr(rbf_pkg::OP_FLOW, 4'h0);
		#1;
		check("flow drive", {rbf_pkg::ENC_FLOW_N, 8'ha5, 1'b1, 7'h04}, busOut);
		next;
		check("one byte only", 32'h0, busOut.dataOe);
		apb(1'b0, rbf_pkg::REG_RX_COUNT, 32'h0);
		check("valid used", 32'h0, rdv[16]);
		instr(rbf_pkg::OP_FLOW, 4'h0);
		#1;
		check("nop busy", 32'h1, busy);
		next;
		check("nop done", {1'b0, 5'h1f, 1'b0}, {busy, busOut.ctrlN, busOut.dataOe});
	endtask
	task automatic testSend;
		logic [7:0] expB;
		instr(rbf_pkg::OP_SEND, 4'h1);
		next;
		check("send refused", rbf_pkg::CTRL_IDLE_N, busOut.ctrlN);
		apb(1'b1, rbf_pkg::REG_CONTROL, 32'h2);
		apb(1'b1, rbf_pkg::REG_MSG_OUT, 32'h44332211);
		// second pass finds the word drained, third sends two longwords
		for (int k = 0; k < 3; k++) begin
			if (k == 2)
				apb(1'b1, rbf_pkg::REG_MSG_OUT, 32'h44332211);
			instr(rbf_pkg::OP_SEND, k == 2 ? 4'h2 : 4'h1);
			for (int i = 0; i < (k == 2 ? 8 : 4); i++) begin
				if (i == 0)
					#1;
				else
					next;
				expB = (k == 1 || i > 3) ? 8'h00 : 8'(32'h44332211 >> ((i % 4) * 8));
				check("send byte", {rbf_pkg::ENC_SEND_N, expB, 1'b1},
					{busOut.ctrlN, busOut.data, busOut.dataOe});
			end
			next;
			check("send length", rbf_pkg::CTRL_IDLE_N, busOut.ctrlN);
		end
	endtask
	task automatic testFetch;
		for (int k = 0; k < 2; k++) begin
			instr(rbf_pkg::OP_SLAVE_FETCH, k ? 4'h9 : 4'h0);
			next;
			check("bad length", rbf_pkg::CTRL_IDLE_N, busOut.ctrlN);
		end
		for (int k = 0; k < 2; k++) begin
			instr(k ? rbf_pkg::OP_CHAIN_FETCH : rbf_pkg::OP_SLAVE_FETCH, 4'h1);
			next;
			check("fetch code", k ? rbf_pkg::ENC_CHAIN_FETCH_N : rbf_pkg::ENC_SLAVE_FETCH_N,
				busOut.ctrlN);
			idle;
			apb(1'b0, rbf_pkg::REG_MSG_IN, 32'h0);
			check("fetched word", REPLY, rdv);
		end
		apb(1'b0, rbf_pkg::REG_MSG_IN, 32'h0);
		check("read clears", 32'h0, rdv);
	endtask
	task automatic testSlave;
		apb(1'b1, rbf_pkg::REG_CONTROL, 32'h3);
		apb(1'b1, rbf_pkg::REG_FLOW_BYTE, 32'h15a);
		instr(rbf_pkg::OP_FLOW, 4'h0);
		next;
		check("slave flow", 32'h0, busOut.dataOe);
		@(posedge clk);
		sendGo <= 1'b1;
		repeat (4) @(posedge clk);
		sendGo <= 1'b0;
		apb(1'b0, rbf_pkg::REG_MSG_IN, 32'h0);
		check("snooped word", sendWord, rdv);
		apb(1'b0, rbf_pkg::REG_CONTROL, 32'h0);
		check("control read", 32'h3, rdv);
		apb(1'b1, rbf_pkg::REG_MSG_OUT, 32'h87654321);
		@(posedge clk);
		getGo <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			if (i == 3)
				getGo <= 1'b0;
			#1;
			check("slave reply", {1'b1, 8'(32'h87654321 >> (i * 8))},
				{busOut.dataOe, busOut.data});
		end
		next;
		check("reply ends", 32'h0, busOut.dataOe);
	endtask
	////////////////////////////////////////////////////////////////
	// ceiling well above the roughly 700 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			badCount++;
			endOfTest;
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		testCounts;
		testSnapshot;
		testFlow;
		testSend;
		testFetch;
		testSlave;
		endOfTest;
	end
endmodule
